// *** hw/rss_regs.vh ***
`ifndef RSS_REGS_VH
`define RSS_REGS_VH
// brown-out level fuse codes
`define RSS_DROOP_OFF    3'h7
`define RSS_DROOP_1V8    3'h6
`define RSS_DROOP_2V7    3'h5
`define RSS_DROOP_4V3    3'h4
`define RSS_DROOP_2V3    3'h3
`define RSS_DROOP_2V2    3'h2
`define RSS_DROOP_1V9    3'h1
`define RSS_DROOP_2V0    3'h0
// cause flag bit positions
`define RSS_FLAG_POR     0
`define RSS_FLAG_EXT     1
`define RSS_FLAG_DROOP   2
`define RSS_FLAG_WDT     3
`define RSS_FLAGS_RESET  4'h0
// times in ns, clock period in ns
`define RSS_CLK_NS       25
`define RSS_EXT_MIN_NS   2500
`define RSS_DROOP_MIN_NS 2000
`define RSS_EXT_MIN_CYC  ((`RSS_EXT_MIN_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS)
`define RSS_DROOP_MIN_CYC ((`RSS_DROOP_MIN_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS)
`define RSS_STRETCH_DEF  16'h1000
`endif

// *** hw/rss_sync.v ***
`timescale 1ns/1ps
`default_nettype none
module rss_sync #(
    parameter RESET_VAL = 1'b0
) (
    input  wire clk,
    input  wire rst_n,
    input  wire d,
    output reg  q
);
    reg meta;

    always @(posedge clk) begin
        if (!rst_n) begin
            meta <= RESET_VAL;
            q    <= RESET_VAL;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

// *** hw/rss_sequencer.v ***
// Functional notes
// [RL1] internal reset restores registers, fetch from vector
// [RL2] any active source resets port pins asynchronously
// [RL3] delay counter stretches reset after all inactive
// [RL4] exactly four reset causes are ORed together
// [RL5] long low reset pin causes reset
// [RL6] pin release waits full stretch period
// [RL7] power-on starts counter, supply drop reasserts immediately
// [RL8] decode three-bit brown-out level fuses
// [RL9] brown-out resets at once, releases through counter
// [RL10] ignore brown-out dips shorter than minimum width; pin_reset_async still follows every enabled dip
// [RL11] expired enabled watchdog asserts reset
// [RL12] watchdog keeps running in every sleep
// [RL13] gate input buffers in sleep when io and adc clocks stop
// [RL14] keep wake-up input buffers enabled in sleep
// [RL15] reference powered only when droop, comparator, converter
// [RL16] software waits reference start-up before use
// [RL17] reference kept on in sleep usable at wake
// [RL18] input disable bits switch off pin buffers
// [RL19] watchdog reset is one-cycle pulse, count from fall
// [RL20] sticky cause flags, cleared by zero write
// [RL21] resynchronise sources, keep asynchronous assertion path
// [RL22] counter restarts on any reassertion
`timescale 1ns/1ps
`default_nettype none
`include "rss_regs.vh"
module rss_sequencer #(
    parameter NPINS       = 6,
    parameter CNT_W       = 16,
    parameter STRETCH_CYC = `RSS_STRETCH_DEF
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             power_on_below,
    input  wire             reset_pin_n,
    input  wire             wdt_expire,
    input  wire             wdt_enable,
    input  wire             sleep_active,
    input  wire             droop_below,
    input  wire [2:0]       brownout_level_fuses,
    input  wire [CNT_W-1:0] stretch_cycles,
    input  wire             stretch_from_fuses,
    input  wire             io_clk_stopped,
    input  wire             adc_clk_stopped,
    input  wire [NPINS-1:0] wake_pin_mask,
    input  wire [NPINS-1:0] digital_input_disable_reg,
    input  wire             comparator_uses_ref,
    input  wire             converter_enabled,
    input  wire [3:0]       flag_clear_n,
    output wire             pin_reset_async,
    output reg              internal_reset,
    output reg              wdt_reset_pulse,
    output reg              wdt_run,
    output reg  [3:0]       reset_cause_flags,
    output reg  [7:0]       droop_trigger_level,
    output reg              droop_enabled,
    output reg  [NPINS-1:0] input_buffer_en,
    output reg              ref_enable,
    output reg              ref_ready
);
    localparam ST_HOLD  = 2'h0;
    localparam ST_COUNT = 2'h1;
    localparam ST_RUN   = 2'h2;

    wire             por_s;
    wire             pin_low_s;
    wire             wdt_s;
    wire             droop_s;
    wire             droop_seen;
    reg  [7:0]       ext_cnt;
    reg  [7:0]       drp_cnt;
    reg              ext_active;
    reg              drp_active;
    reg              wdt_prev;
    reg  [CNT_W-1:0] stretch_cnt;
    reg  [1:0]       seq_state;
    reg  [1:0]       next_state;
    reg              any_src;
    reg              stretch_done;
    reg  [7:0]       next_level;
    reg  [CNT_W-1:0] period;
    reg  [3:0]       next_flags;
    reg  [NPINS-1:0] next_buf;
    reg              ref_need;

    // [RL21] two-flop resynchronisers
    rss_sync u_por (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (power_on_below),
        .q     (por_s)
    );
    rss_sync u_pin (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (~reset_pin_n),
        .q     (pin_low_s)
    );
    rss_sync u_wdt (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (wdt_expire),
        .q     (wdt_s)
    );
    rss_sync u_drp (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (droop_below),
        .q     (droop_s)
    );

    // a disabled detector never counts a dip
    assign droop_seen = droop_s & droop_enabled;

    // [RL2] clockless pin reset path; combinational by necessity
    assign pin_reset_async = power_on_below | ~reset_pin_n |
                             (droop_below & droop_enabled) | wdt_reset_pulse;

    // [RL8] fuse decode, level in tenths of a volt
    always @* begin
        case (brownout_level_fuses)
            `RSS_DROOP_1V8: next_level = 8'h12;
            `RSS_DROOP_2V7: next_level = 8'h1b;
            `RSS_DROOP_4V3: next_level = 8'h2b;
            `RSS_DROOP_2V3: next_level = 8'h17;
            `RSS_DROOP_2V2: next_level = 8'h16;
            `RSS_DROOP_1V9: next_level = 8'h13;
            `RSS_DROOP_2V0: next_level = 8'h14;
            default:        next_level = 8'h00;
        endcase
    end

    always @* begin
        period = stretch_from_fuses ? stretch_cycles : STRETCH_CYC[CNT_W-1:0];
        if (period == {CNT_W{1'b0}}) begin
            period = {{(CNT_W-1){1'b0}}, 1'b1};
        end
        // [RL4] four causes ORed
        any_src      = por_s | ext_active | drp_active | wdt_reset_pulse;
        // [RL6] release only after full period
        stretch_done = (stretch_cnt + {{(CNT_W-1){1'b0}}, 1'b1} >= period);
    end

    // [RL3] hold while any source, then count
    always @* begin
        next_state = seq_state;
        case (seq_state)
            ST_HOLD, ST_COUNT: begin
                if (any_src) begin
                    next_state = ST_HOLD;
                end else if (stretch_done) begin
                    next_state = ST_RUN;
                end else begin
                    next_state = ST_COUNT;
                end
            end
            ST_RUN: begin
                // [RL7] immediate reassert, no delay
                if (any_src) begin
                    next_state = ST_HOLD;
                end
            end
            default: begin
                next_state = ST_HOLD;
            end
        endcase
    end

    // [RL1] internal_reset drives the core's register reset
    always @(posedge clk) begin
        if (!rst_n) begin
            seq_state      <= ST_HOLD;
            stretch_cnt    <= {CNT_W{1'b0}};
            internal_reset <= 1'b1;
        end else begin
            seq_state      <= next_state;
            internal_reset <= (next_state != ST_RUN);
            // [RL22] restart on reassertion
            if (any_src) begin
                stretch_cnt <= {CNT_W{1'b0}};
            end else if (next_state == ST_COUNT) begin
                stretch_cnt <= stretch_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // [RL8] registered level and enable
    always @(posedge clk) begin
        if (!rst_n) begin
            droop_trigger_level <= 8'h00;
            droop_enabled       <= 1'b0;
        end else begin
            droop_trigger_level <= next_level;
            droop_enabled       <= (brownout_level_fuses != `RSS_DROOP_OFF);
        end
    end

    // [RL5] pin low must outlast minimum width
    always @(posedge clk) begin
        if (!rst_n) begin
            ext_cnt    <= 8'h00;
            ext_active <= 1'b0;
        end else if (!pin_low_s) begin
            ext_cnt    <= 8'h00;
            ext_active <= 1'b0;
        end else if (ext_cnt >= `RSS_EXT_MIN_CYC) begin
            ext_active <= 1'b1;
        end else begin
            ext_cnt <= ext_cnt + 8'h01;
        end
    end

    // [RL10] short dips filtered out
    // [RL9] long dip resets, release via counter
    always @(posedge clk) begin
        if (!rst_n) begin
            drp_cnt    <= 8'h00;
            drp_active <= 1'b0;
        end else if (!droop_seen) begin
            drp_cnt    <= 8'h00;
            drp_active <= 1'b0;
        end else if (drp_cnt >= `RSS_DROOP_MIN_CYC) begin
            drp_active <= 1'b1;
        end else begin
            drp_cnt <= drp_cnt + 8'h01;
        end
    end

    // [RL11] expiry only counts while enabled
    always @(posedge clk) begin
        if (!rst_n) begin
            wdt_prev        <= 1'b0;
            wdt_reset_pulse <= 1'b0;
            wdt_run         <= 1'b0;
        end else begin
            wdt_prev        <= wdt_s;
            // [RL19] single-cycle pulse on expiry edge
            wdt_reset_pulse <= wdt_s & ~wdt_prev & wdt_enable;
            // [RL12] sleep never stops the watchdog
            wdt_run         <= wdt_enable;
        end
    end

    // [RL20] sticky cause flags, set beats clear
    always @* begin
        next_flags = reset_cause_flags & flag_clear_n;
        if (por_s) begin
            // power-on wipes the other causes
            next_flags = 4'h1;
        end else begin
            if (ext_active) begin
                next_flags[`RSS_FLAG_EXT] = 1'b1;
            end
            if (drp_active) begin
                next_flags[`RSS_FLAG_DROOP] = 1'b1;
            end
            if (wdt_reset_pulse) begin
                next_flags[`RSS_FLAG_WDT] = 1'b1;
            end
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            reset_cause_flags <= `RSS_FLAGS_RESET;
        end else begin
            reset_cause_flags <= next_flags;
        end
    end

    // [RL13] gate buffers in sleep when io and adc clocks stop
    // [RL14] wake pins stay enabled
    // [RL18] disable bits always win for analog pins
    always @* begin
        if (sleep_active && io_clk_stopped && adc_clk_stopped) begin
            next_buf = wake_pin_mask & ~digital_input_disable_reg;
        end else begin
            next_buf = ~digital_input_disable_reg;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            input_buffer_en <= {NPINS{1'b0}};
        end else begin
            input_buffer_en <= next_buf;
        end
    end

    // [RL15] reference on only when a user needs it
    always @* begin
        ref_need = droop_enabled | comparator_uses_ref | converter_enabled;
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            ref_enable <= 1'b0;
            ref_ready  <= 1'b0;
        end else begin
            ref_enable <= ref_need;
            // [RL17] staying on keeps ready; software times start-up
            ref_ready  <= ref_enable & ref_need;
        end
    end
endmodule
`default_nettype wire

// *** verif/rss_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module rss_checker #(
    parameter STRETCH_CYC = 16
) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       power_on_below,
    input wire logic       reset_pin_n,
    input wire logic       wdt_expire,
    input wire logic       wdt_enable,
    input wire logic [2:0] brownout_level_fuses,
    input wire logic       pin_reset_async,
    input wire logic       internal_reset,
    input wire logic       wdt_reset_pulse,
    input wire logic       wdt_run,
    input wire logic [7:0] droop_trigger_level,
    input wire logic       droop_enabled
);
    // cycles since power-on detector was last active
    logic [7:0] quiet;
    always_ff @(posedge clk) begin
        if (power_on_below)
            quiet <= 8'h00;
        else if (quiet != 8'hff)
            quiet <= quiet + 8'h01;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_pin; !reset_pin_n |-> pin_reset_async; endproperty
    a_pin: assert property (p_pin) else $error("pins not reset");
    property p_por; power_on_below |-> pin_reset_async; endproperty
    a_por: assert property (p_por) else $error("pins not reset");
    property p_porc; power_on_below |-> ##[1:4] internal_reset; endproperty
    a_porc: assert property (p_porc) else $error("late core reset");
    property p_rel; $fell(internal_reset) |-> quiet >= STRETCH_CYC; endproperty
    a_rel: assert property (p_rel) else $error("early release");
    property p_wdf; $rose(wdt_expire) && wdt_enable |-> ##[1:5] wdt_reset_pulse; endproperty
    a_wdf: assert property (p_wdf) else $error("no wdt pulse");
    property p_wd1; wdt_reset_pulse |=> !wdt_reset_pulse; endproperty
    a_wd1: assert property (p_wd1) else $error("long wdt pulse");
    property p_wdr; wdt_reset_pulse |-> ##[0:2] internal_reset; endproperty
    a_wdr: assert property (p_wdr) else $error("wdt no reset");
    property p_run; wdt_enable [*3] |-> wdt_run; endproperty
    a_run: assert property (p_run) else $error("wdt stopped");
    property p_off; (brownout_level_fuses == 3'h7) [*3] |->
        !droop_enabled && droop_trigger_level == 8'h00; endproperty
    a_off: assert property (p_off) else $error("bad off code");
    property p_lv5; (brownout_level_fuses == 3'h5) [*3] |->
        droop_enabled && droop_trigger_level == 8'h1b; endproperty
    a_lv5: assert property (p_lv5) else $error("bad level");
endmodule
bind rss_sequencer rss_checker #(.STRETCH_CYC(STRETCH_CYC)) rss_checker_inst (.clk, .rst_n,
    .power_on_below, .reset_pin_n, .wdt_expire, .wdt_enable, .brownout_level_fuses,
    .pin_reset_async, .internal_reset, .wdt_reset_pulse, .wdt_run, .droop_trigger_level,
    .droop_enabled);
`default_nettype wire

// *** verif/rss_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module rss_partner (
    input  wire logic clk,
    output var logic  power_on_below,
    output var logic  reset_pin_n,
    output var logic  wdt_expire,
    output var logic  droop_below
);
    // supply starts below the power-on level
    initial begin
        power_on_below = 1'b1;
        reset_pin_n = 1'b1;
        wdt_expire = 1'b0;
        droop_below = 1'b0;
    end
    task automatic hit(input int src, input int cyc);
        @(negedge clk);
        case (src)
            0: power_on_below = 1'b1;
            1: reset_pin_n = 1'b0;
            2: wdt_expire = 1'b1;
            default: droop_below = 1'b1;
        endcase
        repeat (cyc) @(negedge clk);
        power_on_below = 1'b0;
        reset_pin_n = 1'b1;
        wdt_expire = 1'b0;
        droop_below = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** verif/rss_sequencer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module rss_sequencer_tb;
    logic clk, rst_n, power_on_below, reset_pin_n, wdt_expire, wdt_enable, sleep_active;
    logic droop_below, comparator_uses_ref, converter_enabled, io_clk_stopped, adc_clk_stopped;
    logic pin_reset_async, internal_reset, wdt_reset_pulse, wdt_run, droop_enabled, ref_enable;
    logic ref_ready, stretch_from_fuses;
    logic [15:0] stretch_cycles;
    logic [2:0] brownout_level_fuses;
    logic [3:0] flag_clear_n, reset_cause_flags;
    logic [5:0] wake_pin_mask, digital_input_disable_reg, input_buffer_en;
    logic [7:0] droop_trigger_level;
    logic [7:0] lvl [0:7] = '{8'h14, 8'h13, 8'h16, 8'h17, 8'h2b, 8'h1b, 8'h12, 8'h00};
    int err_count = 0;
    int n_checks = 0;
    rss_sequencer #(.STRETCH_CYC(16)) rss_sequencer_inst (.clk, .rst_n, .power_on_below,
        .reset_pin_n, .wdt_expire, .wdt_enable, .sleep_active, .droop_below,
        .brownout_level_fuses, .stretch_cycles, .stretch_from_fuses,
        .io_clk_stopped, .adc_clk_stopped, .wake_pin_mask, .digital_input_disable_reg,
        .comparator_uses_ref, .converter_enabled, .flag_clear_n, .pin_reset_async,
        .internal_reset, .wdt_reset_pulse, .wdt_run, .reset_cause_flags,
        .droop_trigger_level, .droop_enabled, .input_buffer_en, .ref_enable, .ref_ready);
    rss_partner rss_partner_inst (.clk, .power_on_below, .reset_pin_n, .wdt_expire,
        .droop_below);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
            err_count++;
        end
    endtask
    task automatic results;
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // bounded wait for release, then stretch length and cause flags
    task automatic rel(input logic [3:0] fl, input int mn);
        int n;
        n = 0;
        while (internal_reset !== 1'b0 && n < 400) begin
            @(negedge clk);
            n++;
        end
        chk(16'(n >= mn && n < 400), 16'h0001);
        if (n >= 400)
            results();
        chk(reset_cause_flags, fl);
    endtask
    initial begin
        rst_n = 1'b0;
        {wdt_enable, sleep_active, comparator_uses_ref, converter_enabled} = 4'h0;
        {io_clk_stopped, adc_clk_stopped} = 2'h0;
        brownout_level_fuses = 3'h7;
        flag_clear_n = 4'hf;
        wake_pin_mask = 6'h00;
        digital_input_disable_reg = 6'h00;
        stretch_from_fuses = 1'b0;
        stretch_cycles = 16'h0020;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        rss_partner_inst.hit(0, 2);
        rel(4'h1, 16);
        flag_clear_n = 4'h0;
        @(negedge clk);
        flag_clear_n = 4'hf;
        @(negedge clk);
        chk(reset_cause_flags, 4'h0);
        rss_partner_inst.hit(1, 20);
        repeat (4) @(negedge clk);
        chk(internal_reset, 1'b0);
        rss_partner_inst.hit(1, 120);
        chk(internal_reset, 1'b1);
        rel(4'h2, 16);
        wdt_enable = 1'b1;
        sleep_active = 1'b1;
        rss_partner_inst.hit(2, 1);
        repeat (5) @(negedge clk);
        chk(wdt_run, 1'b1);
        rel(4'ha, 12);
        {wdt_enable, sleep_active} = 2'h0;
        for (int i = 0; i < 8; i++) begin
            brownout_level_fuses = 3'(i);
            repeat (2) @(negedge clk);
            chk(droop_trigger_level, lvl[i]);
            chk(droop_enabled, 1'(i != 7));
        end
        chk(ref_enable, 1'b0);
        chk(ref_ready, 1'b0);
        brownout_level_fuses = 3'h5;
        rss_partner_inst.hit(3, 40);
        repeat (4) @(negedge clk);
        chk(internal_reset, 1'b0);
        chk(ref_enable, 1'b1);
        rss_partner_inst.hit(3, 100);
        chk(internal_reset, 1'b1);
        rel(4'he, 16);
        brownout_level_fuses = 3'h7;
        comparator_uses_ref = 1'b1;
        {sleep_active, io_clk_stopped, adc_clk_stopped} = 3'h7;
        wake_pin_mask = 6'h05;
        repeat (2) @(negedge clk);
        chk(ref_enable, 1'b1);
        chk(ref_ready, 1'b1);
        chk(input_buffer_en, 6'h05);
        {sleep_active, io_clk_stopped, adc_clk_stopped} = 3'h0;
        digital_input_disable_reg = 6'h03;
        repeat (2) @(negedge clk);
        chk(input_buffer_en, 6'h3c);
        // fuse-selected stretch of 32 cycles must be honoured
        stretch_from_fuses = 1'b1;
        rss_partner_inst.hit(1, 120);
        rel(4'he, 30);
        results();
    end
endmodule
`default_nettype wire
